/* ssw_cpu_model.sv */
// Partner model: processor that strobes the watchdog kick
`timescale 1ns/1ps
module ssw_cpu_model (
    // Clock and reset seen by the processor
    input  wire logic       core_clk,
    input  wire logic       sys_reset_n,
    // Pace set by the bench, a large gap is a slow processor
    input  wire logic       kick_en,
    input  wire logic [7:0] kick_gap,
    // Watchdog strobe
    output logic            watchdog_kick
);
    // ==========
    // Kick timer; a processor held in reset runs no code
    logic [7:0] gap_q;
    initial watchdog_kick = 1'b0;
    always @(posedge core_clk)
        if (!sys_reset_n || !kick_en) gap_q <= 8'h00;
        else if (gap_q == kick_gap) begin
            gap_q <= 8'h00;
            watchdog_kick <= ~watchdog_kick;
        end else gap_q <= gap_q + 8'h01;
endmodule : ssw_cpu_model

/* ssw_pkg.sv */
// Package: constants and carrier types for the supply supervisor with watchdog
package ssw_pkg;

    // ==========================================================
    // Timing
    localparam longint unsigned CLK_HZ            = 64'd125000000;
    localparam longint unsigned HOLD_TIME_US      = 64'd1120000;   // Reset hold time, microseconds
    localparam longint unsigned WD_INIT_TIME_MS   = 64'd35000;     // Initial watchdog period
    localparam longint unsigned WD_NORM_TIME_MS   = 64'd1120;      // Normal watchdog period
    // Least times round up to whole cycles
    localparam longint unsigned HOLD_CYCLES       = (HOLD_TIME_US * CLK_HZ + 64'd999999) / 64'd1000000;
    localparam longint unsigned WD_INIT_CYCLES    = (WD_INIT_TIME_MS * CLK_HZ + 64'd999) / 64'd1000;
    localparam longint unsigned WD_NORM_CYCLES    = (WD_NORM_TIME_MS * CLK_HZ + 64'd999) / 64'd1000;
    localparam int              CNT_W             = 33;

    // ==========================================================
    // Reset state machine
    typedef enum logic [1:0] {
        SSW_RUN    = 2'b00,
        SSW_FAULT  = 2'b01,
        SSW_HOLD   = 2'b10
    } ssw_state_t;

    // ==========================================================
    // Comparator results, high means the level is good
    typedef struct packed {
        logic primary_supply_ok;
        logic secondary_supply_ok;
        logic aux_voltage_ok;
        logic manual_reset_n;
    } ssw_sense_t;

endpackage : ssw_pkg

/* ssw_supervisor.sv */
// Supply supervisor: reset generation, hold timer, dual-mode watchdog, power-fail warning
`timescale 1ns/1ps
module ssw_supervisor
    import ssw_pkg::*;
#(
    parameter longint unsigned HOLD_CNT   = HOLD_CYCLES,
    parameter longint unsigned WD_INIT    = WD_INIT_CYCLES,
    parameter longint unsigned WD_NORM    = WD_NORM_CYCLES,
    parameter bit              HAS_MANUAL = 1'b1,
    parameter bit              HAS_WDOG   = 1'b1,
    parameter bit              HAS_AUX    = 1'b1,
    parameter bit              HAS_PFAIL  = 1'b1
) (
    // Clock and reset
    input  wire logic         core_clk,
    input  wire logic         rst_b,
    // Comparator and control inputs
    input  wire ssw_pkg::ssw_sense_t sense,
    input  wire logic         power_fail_sense,
    input  wire logic         watchdog_kick,
    // Reset and warning outputs
    output logic              sys_reset_out,
    output logic              sys_reset_out_a_n,
    output logic              sys_reset_out_b_n,
    output logic              power_fail_warn_n
);
    import ssw_pkg::*;

    // ==========================================================
    // Fault decode
    localparam logic [CNT_W-1:0] HOLD_LAST = CNT_W'(HOLD_CNT - 64'd1);
    localparam logic [CNT_W-1:0] INIT_LAST = CNT_W'(WD_INIT - 64'd1);
    localparam logic [CNT_W-1:0] NORM_LAST = CNT_W'(WD_NORM - 64'd1);

    ssw_state_t        state_q, state_d;
    logic [CNT_W-1:0]  hold_cnt_q, hold_cnt_d;
    logic [CNT_W-1:0]  wd_cnt_q, wd_cnt_d;
    logic              wd_normal_q, wd_normal_d;
    logic              kick_q;
    logic              rst_q;
    logic              warn_q;

    wire               rail_fault;
    wire               aux_fault;
    wire               manual_fault;
    wire               level_fault;
    wire               kick_edge;
    wire               wd_last;
    wire               wd_expire;
    wire               hold_done;
    wire               rst_d;
    wire               rst_n_d;
    wire               warn_d;

    assign rail_fault   = ~sense.primary_supply_ok | ~sense.secondary_supply_ok;
    assign aux_fault    = HAS_AUX & ~sense.aux_voltage_ok;
    assign manual_fault = HAS_MANUAL & ~sense.manual_reset_n;
    // Any level fault keeps the machine in FAULT; leaving it always starts a fresh hold
    assign level_fault  = rail_fault | aux_fault | manual_fault;
    // Both edges count, so a processor that only sets and clears its pin still kicks
    assign kick_edge    = watchdog_kick ^ kick_q;
    assign wd_last      = wd_normal_q ? (wd_cnt_q == NORM_LAST) : (wd_cnt_q == INIT_LAST);
    assign wd_expire    = HAS_WDOG & (state_q == SSW_RUN) & wd_last & ~kick_edge;
    assign hold_done    = hold_cnt_q == HOLD_LAST;
    // Next reset output values come from state_d, so reset outputs move on the same edge as the state
    assign rst_d        = (state_d != SSW_RUN);
    assign rst_n_d      = (state_d == SSW_RUN);
    assign warn_d       = ~HAS_PFAIL | power_fail_sense;

    // ==========================================================
    // Reset state machine
    always_comb begin
        state_d    = state_q;
        hold_cnt_d = hold_cnt_q;
        case (state_q)
            SSW_RUN: begin
                if (level_fault) begin
                    state_d = SSW_FAULT;
                end else if (wd_expire) begin
                    state_d    = SSW_HOLD;
                    hold_cnt_d = '0;
                end
            end
            SSW_FAULT: begin
                hold_cnt_d = '0;
                if (!level_fault) begin
                    state_d = SSW_HOLD;
                end
            end
            SSW_HOLD: begin
                if (level_fault) begin
                    state_d = SSW_FAULT;
                end else if (hold_done) begin
                    state_d = SSW_RUN;
                end else begin
                    hold_cnt_d = hold_cnt_q + CNT_W'(1);
                end
            end
            default: begin
                state_d = SSW_FAULT;
            end
        endcase
    end

    // ==========================================================
    // Watchdog: runs only while reset is released
    always_comb begin
        wd_cnt_d    = wd_cnt_q + CNT_W'(1);
        wd_normal_d = wd_normal_q;
        if (state_q != SSW_RUN) begin
            wd_cnt_d    = '0;
            wd_normal_d = 1'b0;
        end else if (kick_edge) begin
            wd_cnt_d    = '0;
            wd_normal_d = 1'b1;
        end else if (wd_last) begin
            wd_cnt_d = '0;
        end
    end

    // ==========================================================
    // Registers; power-up counts as a reset event, so reset starts asserted
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            state_q <= SSW_FAULT;
        end else begin
            state_q <= state_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            hold_cnt_q <= '0;
        end else begin
            hold_cnt_q <= hold_cnt_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wd_cnt_q <= '0;
        end else begin
            wd_cnt_q <= wd_cnt_d;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            wd_normal_q <= 1'b0;
        end else begin
            wd_normal_q <= wd_normal_d;
        end
    end

    // Kick level is tracked through reset so a stale level never looks like an edge
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            kick_q <= 1'b0;
        end else begin
            kick_q <= watchdog_kick;
        end
    end

    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_q <= 1'b1;
        end else begin
            rst_q <= rst_d;
        end
    end

    // Complement flop keeps the active-low output registered instead of an inverter
    logic rst_n_q;
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            rst_n_q <= 1'b0;
        end else begin
            rst_n_q <= rst_n_d;
        end
    end

    // No hold on the warning: it only lags the comparator by one cycle
    always_ff @(posedge core_clk or negedge rst_b) begin
        if (!rst_b) begin
            warn_q <= 1'b1;
        end else begin
            warn_q <= warn_d;
        end
    end

    // ==========================================================
    // Outputs; both active-low copies share one flop so they can never disagree
    logic [1:0] rst_low_n;
    for (genvar g = 0; g < 2; g++) begin : g_rst_low
        assign rst_low_n[g] = rst_n_q;
    end

    assign sys_reset_out     = rst_q;
    assign sys_reset_out_a_n = rst_low_n[0];
    assign sys_reset_out_b_n = rst_low_n[1];
    assign power_fail_warn_n = warn_q;
    // hold length and feature presence are the module parameters above

endmodule : ssw_supervisor

/* ssw_supervisor_assertions.sv */
// Checker: port-level properties of the supervisor
`timescale 1ns/1ps
module ssw_checker
    import ssw_pkg::*;
#(parameter longint unsigned HOLD_CNT = 20) (
    // Clock, reset and inputs
    input wire logic                core_clk,
    input wire logic                rst_b,
    input wire ssw_pkg::ssw_sense_t sense,
    input wire logic                power_fail_sense,
    input wire logic                watchdog_kick,
    // Outputs
    input wire logic                sys_reset_out,
    input wire logic                sys_reset_out_a_n,
    input wire logic                sys_reset_out_b_n,
    input wire logic                power_fail_warn_n
);
    // ==========
    // Properties; good_q saturates so long calm runs cannot wrap it
    wire all_ok = &sense;
    logic [7:0] good_q;
    localparam logic [7:0] HOLD_MIN = (HOLD_CNT > 64'd255) ? 8'hff : 8'(HOLD_CNT);
    always_ff @(posedge core_clk or negedge rst_b)
        if (!rst_b) good_q <= 8'h00;
        else good_q <= all_ok ? good_q + 8'(good_q != 8'hff) : 8'h00;
    default clocking @(posedge core_clk); endclocking
    default disable iff (!rst_b);
    warn_low_a: assert property (!power_fail_sense |=> !power_fail_warn_n) else $error("warn high");
    warn_free_a: assert property (power_fail_sense |=> power_fail_warn_n) else $error("warn held");
    fault_rst_a: assert property (!all_ok |=> sys_reset_out) else $error("no reset");
    low_pair_a: assert property (sys_reset_out_a_n == sys_reset_out_b_n) else $error("pair");
    rst_comp_a: assert property (sys_reset_out != sys_reset_out_a_n) else $error("complement");
    hold_min_a: assert property ($fell(sys_reset_out) |-> good_q >= HOLD_MIN) else $error("short");
    hold_keep_a: assert property ($rose(all_ok) |-> sys_reset_out[*8]) else $error("dropped");
    wdog_cause_a: assert property ($rose(sys_reset_out) && $past(all_ok)
        |-> $past(watchdog_kick) == $past(watchdog_kick, 2)) else $error("wdog");
    kick_clear_a: assert property (!sys_reset_out && all_ok && $changed(watchdog_kick)
        |=> !sys_reset_out) else $error("kick");
    cover property ($rose(sys_reset_out) && $past(all_ok));
    cover property ($fell(power_fail_warn_n));
    cover property ($fell(sys_reset_out));
endmodule : ssw_checker
bind ssw_supervisor ssw_checker #(.HOLD_CNT(HOLD_CNT)) ssw_checker_i (.core_clk, .rst_b, .sense,
    .power_fail_sense, .watchdog_kick, .sys_reset_out, .sys_reset_out_a_n, .sys_reset_out_b_n,
    .power_fail_warn_n);

/* ssw_supervisor_bench.sv */
// Testbench: supervisor scenarios with a kicking processor model
`timescale 1ns/1ps
module ssw_supervisor_bench;
    import ssw_pkg::*;
    // ==========
    // Design, model and stimulus
    localparam int HC = 20, WI = 200, WN = 50;
    logic core_clk = 1'b0, rst_b = 1'b0, power_fail_sense = 1'b1, ken = 1'b1, watchdog_kick;
    logic sys_reset_out, sys_reset_out_a_n, sys_reset_out_b_n, power_fail_warn_n;
    logic [7:0] gap = 8'h0a;
    ssw_sense_t sense = 4'hf;
    int num_errors = 0, checked = 0, n;
    initial forever #4 core_clk = ~core_clk;
    ssw_supervisor #(.HOLD_CNT(HC), .WD_INIT(WI), .WD_NORM(WN)) ssw_supervisor_i (.core_clk, .rst_b,
        .sense, .power_fail_sense, .watchdog_kick, .sys_reset_out, .sys_reset_out_a_n,
        .sys_reset_out_b_n, .power_fail_warn_n);
    ssw_cpu_model ssw_cpu_model_i (.core_clk, .sys_reset_n(sys_reset_out_a_n), .kick_en(ken),
        .kick_gap(gap), .watchdog_kick);
    task automatic cyc(input int c);
        repeat (c) @(posedge core_clk);
    endtask : cyc
    task automatic rng(input logic [31:0] got, lo, hi);
        checked++;
        if ((got >= lo && got <= hi) !== 1'b1) begin
            num_errors++;
            $display("Error t=%0t got %h exp %h..%h", $time, got, lo, hi);
        end
    endtask : rng
    task automatic until_lvl(input logic lvl);
        n = 0;
        while (sys_reset_out !== lvl && n < 400) begin
            cyc(1);
            n++;
        end
    endtask : until_lvl
    task automatic t_pfail;
        power_fail_sense <= 1'b0;
        cyc(2);
        rng(power_fail_warn_n, 0, 0);
        power_fail_sense <= 1'b1;
        cyc(2);
        rng(power_fail_warn_n, 1, 1);
    endtask : t_pfail
    task automatic t_faults;
        for (int i = 0; i < 4; i++) begin
            sense[i] <= 1'b0;
            cyc(3);
            rng({sys_reset_out, sys_reset_out_a_n, sys_reset_out_b_n}, 3'h4, 3'h4);
            sense[i] <= 1'b1;
            until_lvl(1'b0);
            rng(n, HC, HC + 3);
        end
    endtask : t_faults
    task automatic t_restart;
        for (int i = 0; i < 4; i++) begin
            sense[i % 2] <= 1'b0;
            cyc(1);
            sense[i % 2] <= 1'b1;
            cyc(5);
        end
        until_lvl(1'b0);
        rng(n, HC - 5, HC - 2);
    endtask : t_restart
    task automatic t_wdog;
        ken <= 1'b0;
        sense[0] <= 1'b0;
        cyc(1);
        sense[0] <= 1'b1;
        cyc(2);
        until_lvl(1'b0);
        until_lvl(1'b1);
        rng(n, WI - 3, WI + 3);
        until_lvl(1'b0);
        rng(n, HC, HC + 3);
        cyc(100);
        rng(sys_reset_out, 0, 0);
        gap <= 8'h1e;
        ken <= 1'b1;
        until_lvl(1'b1);
        rng(n, 400, 400);
        ken <= 1'b0;
        until_lvl(1'b1);
        rng(n, WN - 32, WN + 3);
    endtask : t_wdog
    task automatic summarize;
        $display("errors %0d checks %0d", num_errors, checked);
        if (num_errors == 0 && checked > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask : summarize
    initial begin
        cyc(6);
        rst_b <= 1'b1;
        until_lvl(1'b0);
        rng(n, HC, HC + 3);
        t_pfail();
        t_faults();
        t_restart();
        t_wdog();
        summarize();
    end
    initial begin
        repeat (20000) @(posedge core_clk);
        num_errors++;
        summarize();
    end
endmodule : ssw_supervisor_bench
